// file: design/ppsl_top.v
/*
 * Shared port pin logic: ports 2 and 3, pull-downs on the crystal pins, the shared reset pin,
 * two interrupt-capable pins and analog selection, all behind an Avalon-MM slave.
 * Assumes pins arrive asynchronously and the option strap is steady logic on mclk.
 */
`timescale 1ns/1ps
`default_nettype none
`include "ppsl_defines.vh"

module ppsl_sync #(
   parameter W = 8
) (
   input  wire         mclk,
   input  wire         reset,
   input  wire [W-1:0] din,
   output reg  [W-1:0] dout
);
   reg [W-1:0] s1_r;
   reg [W-1:0] s2_r;
   reg [W-1:0] s3_r;

   // Three stages; the filtered level moves only when stages two and three agree
   always @(posedge mclk or posedge reset)
   begin
      if (reset)
      begin
         s1_r <= {W{1'b0}};
         s2_r <= {W{1'b0}};
         s3_r <= {W{1'b0}};
         dout <= {W{1'b0}};
      end
      else
      begin
         s1_r <= din;
         s2_r <= s1_r;
         s3_r <= s2_r;
         dout <= (dout & (s2_r ^ s3_r)) | (s3_r & ~(s2_r ^ s3_r));
      end
   end
endmodule // ppsl_sync

module ppsl_top #(
   parameter AW = 4
) (
   input  wire          mclk,
   input  wire          reset,
   input  wire [AW-1:0] avs_address,
   input  wire          avs_read,
   input  wire          avs_write,
   input  wire [31:0]   avs_writedata,
   output reg  [31:0]   avs_readdata,
   output reg           avs_waitrequest,
   input  wire [7:0]    p2_in,
   output reg  [7:0]    p2_out_r,
   output reg  [7:0]    p2_oe_n_r,
   output reg  [7:0]    p2_pullup_r,
   input  wire [7:0]    p3_in,
   output reg  [7:0]    p3_out_r,
   output reg  [7:0]    p3_oe_n_r,
   output reg  [7:0]    p3_pullup_r,
   output reg           crystal_in_pin_pulldown_r,
   output reg           crystal_out_pin_pulldown_r,
   output reg  [3:0]    analog_input_channel_r,
   input  wire          shared_reset_input_pin,
   input  wire          option_reset_as_port,
   output reg           chip_reset_hold_r,
   output reg           irq_r
);
   reg  [7:0] p2_mode_r;
   reg  [7:0] p3_mode_r;
   reg  [3:0] analog_mode_select_reg_r;
   reg  [1:0] irq_status_r;
   reg  [1:0] irq_mask_r;
   reg  [1:0] irq_level_r;
   reg        opt_loaded_r;
   reg        opt_port_r;
   wire [7:0] p2_f;
   wire [7:0] p3_f;
   wire [0:0] rst_pin_f;
   wire       acc_go;
   wire       wr_go;
   wire [7:0] analog_ext;
   wire [7:0] p2_view;
   wire [7:0] p3_view;
   wire [1:0] irq_level_nxt;
   wire [1:0] irq_event;
   wire [2:0] bit_idx;
   wire [7:0] bit_one;
   reg  [31:0] rd_nxt;

   ppsl_sync #(.W(8)) u_sync_p2 (.mclk(mclk), .reset(reset), .din(p2_in), .dout(p2_f));
   ppsl_sync #(.W(8)) u_sync_p3 (.mclk(mclk), .reset(reset), .din(p3_in), .dout(p3_f));
   ppsl_sync #(.W(1)) u_sync_rst (.mclk(mclk), .reset(reset),
      .din(shared_reset_input_pin), .dout(rst_pin_f));

   // Bus handshake: a request is answered one cycle later with waitrequest low for one cycle
   // Read data load on the edge that drops waitrequest, so they stand when the master takes them
   assign acc_go = avs_read & avs_waitrequest;
   assign wr_go  = avs_write & ~avs_waitrequest;

   // Port views: input-mode bits show the pin, output bits the latch, analog bits read zero; port 3 bit 4 is set below
   assign analog_ext = {4'h0, analog_mode_select_reg_r};
   assign p2_view = ((p2_f & p2_mode_r) | (p2_out_r & ~p2_mode_r)) & ~analog_ext;
   wire [2:0] p3_view_hi;
   wire [4:0] p3_view_lo;
   wire       p3_b4;
   wire [7:0] p3_raw;
   assign p3_view = {p3_view_hi, p3_view_lo};
   // Port-mode reset pin is read as port 3 bit 4
   assign p3_b4 = opt_port_r ? rst_pin_f[0] : 1'b0;
   assign p3_raw = (p3_f & p3_mode_r) | (p3_out_r & ~p3_mode_r);
   assign p3_view_hi = p3_raw[7:5];
   assign p3_view_lo = {p3_b4, p3_raw[3:0]};

   // Interrupt pin levels follow the driven latch in output mode, the pin otherwise
   assign irq_level_nxt[0] = p2_mode_r[`PPSL_IRQ_A_BIT] ? p2_f[`PPSL_IRQ_A_BIT]
                                                        : p2_out_r[`PPSL_IRQ_A_BIT];
   assign irq_level_nxt[1] = p3_mode_r[`PPSL_IRQ_B_BIT] ? p3_f[`PPSL_IRQ_B_BIT]
                                                        : p3_out_r[`PPSL_IRQ_B_BIT];
   assign irq_event = irq_level_nxt ^ irq_level_r;

   assign bit_idx = avs_writedata[`PPSL_BITOP_IDX_HI:0];
   assign bit_one = 8'h01 << bit_idx;

   // Read multiplexer; unmapped indices read zero
   always @*
   begin
      rd_nxt = 32'h0000_0000;
      case (avs_address)
         `PPSL_REG_P2_DATA:    rd_nxt[7:0] = p2_view;
         `PPSL_REG_P2_MODE:    rd_nxt[7:0] = p2_mode_r;
         `PPSL_REG_P2_ANALOG:  rd_nxt[3:0] = analog_mode_select_reg_r;
         `PPSL_REG_P2_PULLUP:  rd_nxt[7:0] = p2_pullup_r;
         `PPSL_REG_P3_DATA:    rd_nxt[7:0] = p3_view;
         `PPSL_REG_P3_MODE:    rd_nxt[7:0] = p3_mode_r;
         `PPSL_REG_P3_PULLUP:  rd_nxt[7:0] = p3_pullup_r;
         `PPSL_REG_IRQ_STATUS: rd_nxt[1:0] = irq_status_r;
         `PPSL_REG_IRQ_MASK:   rd_nxt[1:0] = irq_mask_r;
         `PPSL_REG_RST_STATUS: rd_nxt[1:0] = {rst_pin_f[0], opt_port_r};
         default:              rd_nxt = 32'h0000_0000;
      endcase
   end

   // Bus slave and port registers
   always @(posedge mclk or posedge reset)
   begin
      if (reset)
      begin
         avs_waitrequest          <= 1'b1;
         avs_readdata             <= 32'h0000_0000;
         p2_out_r                 <= 8'h00;
         p3_out_r                 <= 8'h00;
         p2_mode_r                <= `PPSL_MODE_RESET;
         p3_mode_r                <= `PPSL_MODE_RESET;
         p2_pullup_r              <= 8'h00;
         p3_pullup_r              <= 8'h00;
         analog_mode_select_reg_r <= `PPSL_ANALOG_RESET;
         irq_mask_r               <= `PPSL_MASK_RESET;
      end
      else
      begin
         avs_waitrequest <= ~((avs_read | avs_write) & avs_waitrequest);
         if (acc_go)
            avs_readdata <= rd_nxt;
         if (wr_go)
         begin
            case (avs_address)
               `PPSL_REG_P2_DATA:   p2_out_r <= avs_writedata[7:0];
               `PPSL_REG_P2_MODE:   p2_mode_r <= avs_writedata[7:0];
               `PPSL_REG_P2_ANALOG: analog_mode_select_reg_r <= avs_writedata[3:0];
               `PPSL_REG_P2_PULLUP: p2_pullup_r <= avs_writedata[7:0];
               `PPSL_REG_P3_DATA:   p3_out_r <= avs_writedata[7:0];
               `PPSL_REG_P3_MODE:   p3_mode_r <= avs_writedata[7:0];
               `PPSL_REG_P3_PULLUP: p3_pullup_r <= avs_writedata[7:0];
               `PPSL_REG_IRQ_MASK:  irq_mask_r <= avs_writedata[1:0];
               `PPSL_REG_BITOP:
               begin
                  // Byte-wide read-modify-write: every latch bit is rewritten from the port view
                  if (avs_writedata[`PPSL_BITOP_PORT])
                     p3_out_r <= avs_writedata[`PPSL_BITOP_VAL] ? (p3_view | bit_one)
                                                                : (p3_view & ~bit_one);
                  else
                     p2_out_r <= avs_writedata[`PPSL_BITOP_VAL] ? (p2_view | bit_one)
                                                                : (p2_view & ~bit_one);
               end
               default:
               begin
               end
            endcase
         end
      end
   end

   // Pin drive: an input-mode or analog bit releases its driver
   always @(posedge mclk or posedge reset)
   begin
      if (reset)
      begin
         p2_oe_n_r              <= `PPSL_MODE_RESET;
         p3_oe_n_r              <= `PPSL_MODE_RESET;
         analog_input_channel_r <= `PPSL_ANALOG_RESET;
      end
      else
      begin
         p2_oe_n_r              <= p2_mode_r | analog_ext;
         p3_oe_n_r              <= p3_mode_r;
         analog_input_channel_r <= analog_mode_select_reg_r;
      end
   end

   // Crystal pin pull-downs: on under reset, off afterwards
   always @(posedge mclk or posedge reset)
   begin
      if (reset)
      begin
         crystal_in_pin_pulldown_r  <= 1'b1;
         crystal_out_pin_pulldown_r <= 1'b1;
      end
      else
      begin
         crystal_in_pin_pulldown_r  <= 1'b0;
         crystal_out_pin_pulldown_r <= 1'b0;
      end
   end

   // Option strap taken once after release, only when the reset pin is seen high;
   // a low pin before that keeps the chip in reset whatever the strap says
   always @(posedge mclk or posedge reset)
   begin
      if (reset)
      begin
         opt_loaded_r      <= 1'b0;
         opt_port_r        <= 1'b0;
         chip_reset_hold_r <= 1'b1;
      end
      else
      begin
         if (!opt_loaded_r)
         begin
            chip_reset_hold_r <= 1'b1;
            if (rst_pin_f[0])
            begin
               opt_loaded_r <= 1'b1;
               opt_port_r   <= option_reset_as_port;
            end
         end
         else
            chip_reset_hold_r <= ~opt_port_r & ~rst_pin_f[0];
      end
   end

   // Interrupt flags: set wins over a write-one clear
   always @(posedge mclk or posedge reset)
   begin
      if (reset)
      begin
         irq_level_r  <= 2'h0;
         irq_status_r <= 2'h0;
         irq_r        <= 1'b0;
      end
      else
      begin
         irq_level_r <= irq_level_nxt;
         if (wr_go && (avs_address == `PPSL_REG_IRQ_STATUS))
            irq_status_r <= (irq_status_r & ~avs_writedata[1:0]) | irq_event;
         else
            irq_status_r <= irq_status_r | irq_event;
         irq_r <= |(irq_status_r & ~irq_mask_r);
      end
   end
endmodule // ppsl_top
`default_nettype wire

// file: inc/ppsl_defines.vh
/*
 * Constants of the shared port pin logic: register indices, field positions and reset values.
 * Assumes the top module sees a word-addressed Avalon-MM slave port.
 */
// Function
// - While reset is active, the two port 2 pins shared with the crystal are pulled down.
// - With the option byte set to port use, the shared reset pin no longer resets the chip.
// - The option byte is taken only after reset release, and a low reset pin before that keeps reset.
// - A level change on either interrupt-capable pin in output mode sets its request flag.
// - An analog select bit at 1 turns off the digital port on its pin and routes it to the A/D.
// - A single-bit port operation rewrites the whole byte, so input-mode latches take the pin level.
`ifndef PPSL_DEFINES_VH
`define PPSL_DEFINES_VH
`define PPSL_REG_P2_DATA    4'h0
`define PPSL_REG_P2_MODE    4'h1
`define PPSL_REG_P2_ANALOG  4'h2
`define PPSL_REG_P2_PULLUP  4'h3
`define PPSL_REG_P3_DATA    4'h4
`define PPSL_REG_P3_MODE    4'h5
`define PPSL_REG_P3_PULLUP  4'h6
`define PPSL_REG_BITOP      4'h7
`define PPSL_REG_IRQ_STATUS 4'h8
`define PPSL_REG_IRQ_MASK   4'h9
`define PPSL_REG_RST_STATUS 4'ha
`define PPSL_MODE_RESET     8'hff
`define PPSL_ANALOG_RESET   4'h0
`define PPSL_MASK_RESET     2'h3
`define PPSL_BITOP_IDX_HI   2
`define PPSL_BITOP_VAL      3
`define PPSL_BITOP_PORT     4
`define PPSL_IRQ_A_BIT      1
`define PPSL_IRQ_B_BIT      2
`define PPSL_XOUT_BIT       2
`define PPSL_XIN_BIT        3
`define PPSL_RSTPIN_BIT     4
`endif

// file: verification/ppsl_props.sv
/* Port checks for ppsl_top: pull-downs, reset pin, analog select, bus answer.
   Assumes it is bound to ppsl_top from the testbench. */
`timescale 1ns/1ps
`default_nettype none
module ppsl_props (
   input wire logic       mclk,
   input wire logic       reset,
   input wire logic       avs_read,
   input wire logic       avs_write,
   input wire logic       avs_waitrequest,
   input wire logic [7:0] p2_oe_n_r,
   input wire logic [3:0] analog_input_channel_r,
   input wire logic       crystal_in_pin_pulldown_r,
   input wire logic       crystal_out_pin_pulldown_r,
   input wire logic       shared_reset_input_pin,
   input wire logic       option_reset_as_port,
   input wire logic       chip_reset_hold_r,
   input wire logic       irq_r
);
   default clocking @(posedge mclk); endclocking
   default disable iff (reset);
   // Pull-downs follow reset
   pd_in_reset_a: assert property (disable iff (1'b0) reset |->
      crystal_in_pin_pulldown_r && crystal_out_pin_pulldown_r) else $error("pulldown off in reset");
   pd_released_a: assert property (!$past(reset) |->
      !crystal_in_pin_pulldown_r && !crystal_out_pin_pulldown_r) else $error("pulldown after reset");
   // Reset pin as port or as reset source
   port_mode_a: assert property (option_reset_as_port && !chip_reset_hold_r |=> !chip_reset_hold_r)
      else $error("port mode pin reasserted reset");
   pin_low_hold_a: assert property ((!option_reset_as_port && !shared_reset_input_pin) [*8]
      |-> chip_reset_hold_r) else $error("low reset pin not holding");
   // Analog pins not driven while the channel selection holds steady
   analog_oe_a: assert property ($stable(analog_input_channel_r) |->
      (analog_input_channel_r & ~p2_oe_n_r[3:0]) == 4'h0) else $error("analog pin driven");
   // Bus answer one cycle after the request, for one cycle
   wait_answer_a: assert property ((avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
      else $error("no answer");
   wait_single_a: assert property (!avs_waitrequest |=> avs_waitrequest)
      else $error("answer too long");
   // Main scenarios
   cover property (avs_write && !avs_waitrequest);
   cover property ($rose(irq_r));
   cover property ($fell(chip_reset_hold_r));
endmodule // ppsl_props
`default_nettype wire

// file: verification/test_ppsl_top.sv
/* Self-checking testbench for ppsl_top, one task per scenario.
   Assumes the design and ppsl_props.sv are compiled before it. */
`timescale 1ns/1ps
`default_nettype none
module test_ppsl_top;
   logic        mclk, reset, avs_read, avs_write, avs_waitrequest, irq_r;
   logic        shared_reset_input_pin, option_reset_as_port, chip_reset_hold_r;
   logic        crystal_in_pin_pulldown_r, crystal_out_pin_pulldown_r;
   logic [3:0]  avs_address, analog_input_channel_r;
   logic [31:0] avs_writedata, avs_readdata;
   logic [7:0]  p2_in, p2_out_r, p2_oe_n_r, p2_pullup_r, p3_in, p3_out_r, p3_oe_n_r, p3_pullup_r;
   integer      miscompares = 0;
   integer      num_checks = 0;
   ppsl_top dut (.mclk(mclk), .reset(reset), .avs_address(avs_address), .avs_read(avs_read),
      .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
      .avs_waitrequest(avs_waitrequest), .p2_in(p2_in), .p2_out_r(p2_out_r),
      .p2_oe_n_r(p2_oe_n_r), .p2_pullup_r(p2_pullup_r), .p3_in(p3_in), .p3_out_r(p3_out_r),
      .p3_oe_n_r(p3_oe_n_r), .p3_pullup_r(p3_pullup_r), .irq_r(irq_r),
      .crystal_in_pin_pulldown_r(crystal_in_pin_pulldown_r), .chip_reset_hold_r(chip_reset_hold_r),
      .crystal_out_pin_pulldown_r(crystal_out_pin_pulldown_r),
      .analog_input_channel_r(analog_input_channel_r),
      .shared_reset_input_pin(shared_reset_input_pin), .option_reset_as_port(option_reset_as_port));
   // Clock
   initial
   begin
      mclk = 1'b0;
      forever #2.5 mclk = ~mclk;
   end
   // Compare and count
   task chk(input string nm, input [31:0] e, input [31:0] g);
      begin
         num_checks = num_checks + 1;
         if (g !== e)
         begin
            miscompares = miscompares + 1;
            $display("ERROR %s expected %h seen %h", nm, e, g);
         end
      end
   endtask
   // Bus cycle, held until waitrequest is sampled low
   task bus(input rd, input [3:0] a, input [31:0] d);
      integer n;
      begin
         n = 0;
         @(posedge mclk);
         avs_address <= a;
         avs_writedata <= d;
         avs_read <= rd;
         avs_write <= !rd;
         @(posedge mclk);
         while (avs_waitrequest !== 1'b0 && n < 100)
         begin
            @(posedge mclk);
            n = n + 1;
         end
         avs_read <= 1'b0;
         avs_write <= 1'b0;
         if (avs_waitrequest !== 1'b0)
         begin
            miscompares = miscompares + 1;
            $display("ERROR waitrequest expected 0 seen %b", avs_waitrequest);
         end
         if (rd)
            chk("readdata", d, avs_readdata);
      end
   endtask
   // Interrupt flags from output changes, masked then unmasked
   task t_irq;
      begin
         bus(0, 4'h9, 32'h3);
         bus(0, 4'h1, 32'hfd);
         bus(0, 4'h5, 32'hfb);
         bus(0, 4'h0, 32'h02);
         bus(0, 4'h4, 32'h04);
         bus(1, 4'h8, 32'h3);
         chk("irq masked", 32'h0, irq_r);
         bus(0, 4'h9, 32'h2);
         repeat (3) @(posedge mclk);
         chk("irq on", 32'h1, irq_r);
         chk("p3 oe_n", 32'hfb, p3_oe_n_r);
         bus(0, 4'h8, 32'h1);
         bus(1, 4'h8, 32'h2);
         chk("irq off", 32'h0, irq_r);
      end
   endtask
   // Analog select releases the pin and reads 0
   task t_analog;
      begin
         bus(0, 4'h1, 32'h00);
         bus(0, 4'h3, 32'h80);
         bus(0, 4'h0, 32'h07);
         bus(0, 4'h2, 32'h5);
         repeat (2) @(posedge mclk);
         chk("analog", 32'h5, analog_input_channel_r);
         chk("oe_n", 32'h5, p2_oe_n_r[3:0]);
         chk("pullup", 32'h80, p2_pullup_r);
         bus(1, 4'h0, 32'h02);
         bus(0, 4'h2, 32'h0);
      end
   endtask
   // Single-bit set and clear rewrite the whole latch byte
   task t_bitop;
      begin
         p2_in <= 8'ha5;
         p3_in <= 8'h21;
         bus(0, 4'h6, 32'h11);
         bus(0, 4'h1, 32'hf0);
         bus(0, 4'h0, 32'h03);
         bus(0, 4'h7, 32'h0a);
         @(posedge mclk);
         chk("p2 latch", 32'ha7, p2_out_r);
         chk("p3 pullup", 32'h11, p3_pullup_r);
         bus(0, 4'h7, 32'h12);
         @(posedge mclk);
         chk("p3 latch", 32'h21, p3_out_r);
         bus(1, 4'h7, 32'h0);
      end
   endtask
   // Reset pin held low across a reset, then raised
   task t_rstpin(input o);
      begin
         option_reset_as_port <= o;
         shared_reset_input_pin <= 1'b0;
         reset <= 1'b1;
         repeat (16) @(posedge mclk);
         reset <= 1'b0;
         repeat (20) @(posedge mclk);
         chk("hold", 32'h1, chip_reset_hold_r);
         shared_reset_input_pin <= 1'b1;
         repeat (10) @(posedge mclk);
         chk("hold high pin", 32'h0, chip_reset_hold_r);
         bus(1, 4'ha, {30'h0, 1'b1, o});
         shared_reset_input_pin <= 1'b0;
         repeat (10) @(posedge mclk);
         chk("hold low pin", {31'h0, !o}, chip_reset_hold_r);
      end
   endtask
   // Verdict
   task complete_run;
      begin
         $display("checks %0d miscompares %0d", num_checks, miscompares);
         if (miscompares == 0 && num_checks > 0)
            $display("Regression OK");
         else
            $display("Regression broken");
         $finish;
      end
   endtask
   // Main sequence
   initial
   begin
      reset = 1'b1;
      {avs_read, avs_write, avs_address, avs_writedata} = '0;
      {p2_in, p3_in, option_reset_as_port} = '0;
      shared_reset_input_pin = 1'b1;
      repeat (16) @(posedge mclk);
      chk("pulldown", 32'h3, {crystal_in_pin_pulldown_r, crystal_out_pin_pulldown_r});
      reset <= 1'b0;
      repeat (3) @(posedge mclk);
      chk("pd off", 32'h0, {crystal_in_pin_pulldown_r, crystal_out_pin_pulldown_r});
      bus(1, 4'h1, 32'hff);
      bus(1, 4'hb, 32'h0);
      t_irq;
      t_analog;
      t_bitop;
      t_rstpin(1'b0);
      t_rstpin(1'b1);
      complete_run;
   end
   // Watchdog
   initial
   begin
      #20000;
      miscompares = miscompares + 1;
      complete_run;
   end
endmodule // test_ppsl_top
bind ppsl_top ppsl_props u_props (.mclk(mclk), .reset(reset), .avs_read(avs_read),
   .avs_write(avs_write), .avs_waitrequest(avs_waitrequest), .p2_oe_n_r(p2_oe_n_r), .irq_r(irq_r),
   .analog_input_channel_r(analog_input_channel_r), .chip_reset_hold_r(chip_reset_hold_r),
   .crystal_in_pin_pulldown_r(crystal_in_pin_pulldown_r),
   .crystal_out_pin_pulldown_r(crystal_out_pin_pulldown_r),
   .shared_reset_input_pin(shared_reset_input_pin), .option_reset_as_port(option_reset_as_port));
`default_nettype wire
